/* File: hw/sas_sequencer.sv */
// Converter sequencer: registers on APB, timing and SAR control
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic [9:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_i,
  input wire logic rc_half_tick_i,
  input wire logic [3:0] compare_unit_mode_i,
  input wire logic ccp_event_i,
  output logic timer_reset_o,
  input wire logic compare_i,
  output logic [7:0] trial_code_o,
  output logic sample_o,
  output logic [2:0] channel_o,
  output logic vref_external_o,
  output logic [7:0] analog_pins_o,
  output logic module_power_o,
  input wire logic [7:0] port_pins_i,
  output logic [7:0] port_read_o,
  output logic irq_o,
  output logic wake_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin role decode: bit n is channel n (RA0,RA1,RA2,RA3,RA5,RE0..RE2)
  function automatic logic [7:0] analog_mask(input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    unique case (code)
      3'h0: m = 8'hff;
      3'h1: m = 8'hf7;
      3'h2: m = 8'h1f;
      3'h3: m = 8'h17;
      3'h4: m = 8'h0b;
      3'h5: m = 8'h03;
      3'h6, 3'h7: m = 8'h00;
    endcase
    return m;
  endfunction

  // Reference comes from RA3 on odd codes below 110
  function automatic logic ext_ref(input logic [2:0] code);
    return code[0] & ~(code[2] & code[1]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [1:0] clk_sel, next_clk_sel;
  logic [2:0] chan_sel, next_chan_sel;
  logic go, next_go;
  logic conv_on, next_conv_on;
  logic [2:0] pin_role, next_pin_role;
  logic [7:0] result, next_result;
  logic done_flag, next_done_flag;
  logic done_ie, next_done_ie;
  logic periph_ie, next_periph_ie;
  logic global_ie, next_global_ie;
  logic powered_down, next_powered_down;
  sas_pkg::sas_state_e state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [3:0] div, next_div;
  logic [7:0] trial, next_trial;
  logic [7:0] mask, next_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_timer_reset, next_wake;

  // Decoded bus access; writes taken only at the completing access edge, reads at setup
  logic [7:0] idx;
  logic wr_en;
  logic active;
  logic half_tick;
  logic [3:0] half_len;
  logic completing;

  assign idx = paddr_i[9:2];
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign active = conv_on & ~powered_down;

  ////////////////////////////////////////////////////////////////////////
  // Half bit-period tick from the selected source
  always_comb begin
    unique case (clk_sel)
      sas_pkg::CLK_DIV2: half_len = sas_pkg::HALF_DIV2; // [RULE8] [RULE24]
      sas_pkg::CLK_DIV8: half_len = sas_pkg::HALF_DIV8;
      sas_pkg::CLK_DIV32: half_len = sas_pkg::HALF_DIV32;
      sas_pkg::CLK_RC: half_len = sas_pkg::HALF_DIV2;
    endcase
    if (clk_sel == sas_pkg::CLK_RC) begin
      half_tick = rc_half_tick_i; // [RULE8]
    end else begin
      half_tick = (4'(div + 4'h1) == half_len);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: ready in the first access cycle, no wait states
  always_comb begin
    next_pready = psel_i & ~penable_i;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel_i & ~penable_i) begin
      unique case (idx)
        sas_pkg::IDX_IRQ_CONTROL:
          next_prdata[7:6] = {global_ie, periph_ie};
        sas_pkg::IDX_PERIPH_FLAGS:
          next_prdata[sas_pkg::DONE_BIT] = done_flag;
        sas_pkg::IDX_RESULT:
          next_prdata[7:0] = result;
        sas_pkg::IDX_CONTROL_ZERO:
          // Bit 1 reads zero [RULE26]
          next_prdata[7:0] = {clk_sel, chan_sel, go, 1'b0, conv_on};
        sas_pkg::IDX_PERIPH_ENABLES:
          next_prdata[sas_pkg::DONE_IE_BIT] = done_ie;
        sas_pkg::IDX_PIN_ROLE:
          next_prdata[2:0] = pin_role; // Upper bits zero [RULE3]
        default:
          next_pslverr = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, sequencer and side effects
  always_comb begin
    next_clk_sel = clk_sel;
    next_chan_sel = chan_sel;
    next_go = go;
    next_conv_on = conv_on;
    next_pin_role = pin_role;
    next_result = result;
    next_done_flag = done_flag;
    next_done_ie = done_ie;
    next_periph_ie = periph_ie;
    next_global_ie = global_ie;
    next_powered_down = powered_down;
    next_state = state;
    next_cnt = cnt;
    next_trial = trial;
    next_mask = mask;
    next_wake = 1'b0;
    next_timer_reset = 1'b0;
    completing = 1'b0;
    next_div = (clk_sel == sas_pkg::CLK_RC || half_tick) ? 4'h0 :
               4'(div + 4'h1);

    // Software writes
    if (wr_en) begin
      unique case (idx)
        sas_pkg::IDX_IRQ_CONTROL: begin
          next_global_ie = pwdata_i[sas_pkg::GLOBAL_IE_BIT];
          next_periph_ie = pwdata_i[sas_pkg::PERIPH_IE_BIT];
        end
        sas_pkg::IDX_PERIPH_FLAGS:
          next_done_flag = pwdata_i[sas_pkg::DONE_BIT];
        sas_pkg::IDX_RESULT:
          next_result = pwdata_i[7:0];
        sas_pkg::IDX_CONTROL_ZERO: begin
          next_clk_sel = pwdata_i[sas_pkg::CLKSEL_MSB:sas_pkg::CLKSEL_LSB];
          next_chan_sel = pwdata_i[sas_pkg::CHAN_MSB:sas_pkg::CHAN_LSB];
          next_conv_on = pwdata_i[sas_pkg::ON_BIT]; // [RULE26]
          // Go only starts from an already powered module, so a write
          // that powers up and sets go together does not start [RULE11]
          next_go = pwdata_i[sas_pkg::GO_BIT] & active; // [RULE26]
        end
        sas_pkg::IDX_PERIPH_ENABLES:
          next_done_ie = pwdata_i[sas_pkg::DONE_IE_BIT];
        sas_pkg::IDX_PIN_ROLE:
          next_pin_role = pwdata_i[2:0];
        default: ;
      endcase
    end

    // Compare unit trigger: timer cleared even while off [RULE22]
    if (ccp_event_i && compare_unit_mode_i == sas_pkg::CCP_TRIGGER_MODE) begin
      next_timer_reset = 1'b1; // [RULE22]
      if (active) begin
        next_go = 1'b1; // [RULE22]
      end
    end

    // Sequencer
    unique case (state)
      sas_pkg::SAS_ACQUIRE: begin
        next_cnt = 5'h00;
        if (active && go) begin
          next_div = 4'h0;
          if (clk_sel == sas_pkg::CLK_RC) begin
            next_state = sas_pkg::SAS_DELAY; // [RULE14]
          end else begin
            next_state = sas_pkg::SAS_CONVERT;
          end
        end
      end
      sas_pkg::SAS_DELAY: begin
        // One instruction cycle lets a sleep instruction go first
        next_cnt = 5'(cnt + 5'h01);
        if (!go || !active) begin
          next_state = sas_pkg::SAS_HOLDOFF; // [RULE12]
          next_cnt = 5'h00;
        end else if (5'(cnt + 5'h01) == sas_pkg::INSTR_CYCLES) begin
          next_state = sas_pkg::SAS_CONVERT; // [RULE14]
          next_cnt = 5'h00;
        end
      end
      sas_pkg::SAS_CONVERT: begin
        if (!go || !active) begin
          // Result untouched on abort [RULE12]
          next_state = sas_pkg::SAS_HOLDOFF; // [RULE13]
          next_cnt = 5'h00;
        end else if (half_tick) begin
          next_cnt = 5'(cnt + 5'h01);
          if (cnt == 5'h00) begin
            // First half period is sampling [RULE27]
            next_mask = 8'h80;
            next_trial = 8'h80;
          end else if (cnt[0] == 1'b0 && cnt <= sas_pkg::LAST_BIT_HALF) begin
            // End of a bit period: keep or drop the trial bit [RULE27]
            next_trial = (compare_i ? trial : (trial & ~mask)) |
                         (mask >> 1);
            next_mask = mask >> 1;
          end
          if (5'(cnt + 5'h01) == sas_pkg::CONV_HALVES) begin
            completing = 1'b1; // [RULE7]
          end
        end
      end
      sas_pkg::SAS_HOLDOFF: begin
        if (!active) begin
          next_state = sas_pkg::SAS_ACQUIRE;
        end else if (half_tick) begin
          next_cnt = 5'(cnt + 5'h01);
          if (5'(cnt + 5'h01) == sas_pkg::HOLDOFF_HALVES) begin
            next_state = sas_pkg::SAS_ACQUIRE; // [RULE5] [RULE13]
          end
        end
      end
    endcase

    // Completion: load result, clear go, set done (set wins) [RULE15]
    if (completing) begin
      next_result = trial;
      next_go = 1'b0;
      next_done_flag = 1'b1;
      next_state = sas_pkg::SAS_HOLDOFF; // [RULE5]
      next_cnt = 5'h00;
      if (sleep_i) begin
        if (done_ie) begin
          next_wake = 1'b1; // [RULE17]
        end else begin
          next_powered_down = 1'b1; // Power bit stays set [RULE18]
        end
      end
    end

    // Sleep with a fast clock aborts and powers down [RULE19]
    if (sleep_i && conv_on && clk_sel != sas_pkg::CLK_RC) begin
      next_powered_down = 1'b1; // [RULE19]
      next_go = 1'b0;
      if (state != sas_pkg::SAS_ACQUIRE) begin
        next_state = sas_pkg::SAS_ACQUIRE;
      end
    end

    // Leaving sleep lets the module run again
    if (!sleep_i) begin
      next_powered_down = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers; reset returns all of them, module off [RULE20]
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clk_sel <= sas_pkg::RST_CONTROL_ZERO[7:6];
      chan_sel <= sas_pkg::RST_CONTROL_ZERO[5:3];
      go <= 1'b0; // Aborts any conversion [RULE20]
      conv_on <= 1'b0;
      pin_role <= sas_pkg::RST_PIN_ROLE; // [RULE20]
      done_flag <= 1'b0;
      done_ie <= 1'b0;
      periph_ie <= 1'b0;
      global_ie <= 1'b0;
      powered_down <= 1'b0;
      state <= sas_pkg::SAS_ACQUIRE;
      cnt <= 5'h00;
      div <= 4'h0;
      trial <= 8'h00;
      mask <= 8'h00;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      timer_reset_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      clk_sel <= next_clk_sel;
      chan_sel <= next_chan_sel;
      go <= next_go;
      conv_on <= next_conv_on;
      pin_role <= next_pin_role;
      done_flag <= next_done_flag;
      done_ie <= next_done_ie;
      periph_ie <= next_periph_ie;
      global_ie <= next_global_ie;
      powered_down <= next_powered_down;
      state <= next_state;
      cnt <= next_cnt;
      div <= next_div;
      trial <= next_trial;
      mask <= next_mask;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      timer_reset_o <= next_timer_reset;
      wake_o <= next_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result survives ordinary resets; only power-on clears it. The
  // cleared value stands in for the unknown content. [RULE21]
  always_ff @(posedge clock_i) begin
    if (rst_i && por_i) begin
      result <= sas_pkg::RST_RESULT_POR; // [RULE21]
    end else if (!rst_i) begin
      result <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core and pin facing outputs, all registered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      trial_code_o <= 8'h00;
      sample_o <= 1'b0;
      channel_o <= 3'h0;
      vref_external_o <= 1'b0;
      analog_pins_o <= 8'hff;
      module_power_o <= 1'b0;
      port_read_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      trial_code_o <= next_trial;
      // Channel follows the field regardless of pin direction [RULE10]
      channel_o <= next_chan_sel; // [RULE10] [RULE25]
      sample_o <= (next_conv_on & ~next_powered_down) &
                  (next_state == sas_pkg::SAS_ACQUIRE ||
                   next_state == sas_pkg::SAS_DELAY ||
                   (next_state == sas_pkg::SAS_CONVERT &&
                    next_cnt == 5'h00));
      analog_pins_o <= analog_mask(next_pin_role); // [RULE1] [RULE2]
      vref_external_o <= ext_ref(next_pin_role); // [RULE1] [RULE2]
      module_power_o <= next_conv_on & ~next_powered_down;
      // Analog pins read as low on the port [RULE9]
      port_read_o <= port_pins_i & ~analog_mask(pin_role); // [RULE9]
      irq_o <= next_done_flag & next_done_ie & next_periph_ie &
               next_global_ie; // [RULE16]
    end
  end

endmodule
`default_nettype wire

/* File: hw/sas_pkg.sv */
// Constants and register map of the converter sequencer
//
// Overview of operation
// [RULE1] Pin codes 000-011 set analog pins and supply or RA3 reference.
// [RULE2] Codes 100/101 keep RA0, RA1 (RA3) analog; codes 11x are all digital.
// [RULE3] Pin role register bits 7 to 3 always read zero.
// [RULE4] Software configures pins, channel, clock, power, irq, waits, then starts.
// [RULE5] After a conversion ends, next acquisition waits two bit periods.
// [RULE6] Software waits the acquisition time after a channel change.
// [RULE7] One conversion lasts nine and a half bit periods.
// [RULE8] Bit period is 2, 8 or 32 oscillator periods, or the RC clock.
// [RULE9] Port reads return zero on pins set as analog inputs.
// [RULE10] Conversion runs on the chosen channel whatever pin direction is.
// [RULE11] Software never sets go in the write that powers the module.
// [RULE12] Clearing go mid-conversion aborts it; result keeps its old value.
// [RULE13] After an abort, wait two bit periods, then acquisition resumes.
// [RULE14] With the RC clock, start waits one instruction cycle after go.
// [RULE15] Completion clears go, loads the result, sets the done flag.
// [RULE16] Irq is done and enable, gated by peripheral and global enables.
// [RULE17] Completion in sleep with the irq enabled wakes the device.
// [RULE18] Completion in sleep with irq disabled powers the module down.
// [RULE19] Sleep with a non-RC clock aborts and powers the module down.
// [RULE20] Reset restores registers, disables the module, all pins analog.
// [RULE21] Result is unknown after power-on reset, kept over other resets.
// [RULE22] Compare trigger in mode 1011 sets go if on; always clears timer.
// [RULE23] Software selects channel and waits acquisition before the trigger.
// [RULE24] Clock select field bits 7:6: /2, /8, /32, RC.
// [RULE25] Channel select field bits 5:3 picks channel 0 to 7.
// [RULE26] Bit 2 is go, bit 0 powers the module, bit 1 reads zero.
// [RULE27] Result resolved MSB first, one bit per period, half for sampling.
package sas_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RESULT = 8'h1e;
  localparam logic [7:0] IDX_CONTROL_ZERO = 8'h1f;
  localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PIN_ROLE = 8'h9f;
  localparam int ADDR_W = 10;

  // Field positions
  localparam int CLKSEL_MSB = 7;
  localparam int CLKSEL_LSB = 6;
  localparam int CHAN_MSB = 5;
  localparam int CHAN_LSB = 3;
  localparam int GO_BIT = 2;
  localparam int ON_BIT = 0;
  localparam int DONE_BIT = 6;
  localparam int DONE_IE_BIT = 6;
  localparam int PERIPH_IE_BIT = 6;
  localparam int GLOBAL_IE_BIT = 7;

  // Reset values
  localparam logic [7:0] RST_CONTROL_ZERO = 8'h00;
  localparam logic [2:0] RST_PIN_ROLE = 3'h0;
  localparam logic [7:0] RST_RESULT_POR = 8'h00;

  // Clock select codes and compare trigger mode
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;
  localparam logic [3:0] CCP_TRIGGER_MODE = 4'hb;

  // Half bit-period lengths in oscillator cycles
  localparam logic [3:0] HALF_DIV2 = 4'h1;
  localparam logic [3:0] HALF_DIV8 = 4'h4;
  localparam logic [3:0] HALF_DIV32 = 4'h0; // 16 wraps to zero
  // Conversion and hold-off in half bit periods
  localparam logic [4:0] CONV_HALVES = 5'h13; // 9.5 periods
  localparam logic [4:0] LAST_BIT_HALF = 5'h11;
  localparam logic [4:0] HOLDOFF_HALVES = 5'h04; // 2 periods
  // One instruction cycle in oscillator cycles
  localparam logic [4:0] INSTR_CYCLES = 5'h04;

  typedef enum logic [3:0] {
    SAS_ACQUIRE = 4'b0001,
    SAS_DELAY = 4'b0010,
    SAS_CONVERT = 4'b0100,
    SAS_HOLDOFF = 4'b1000
  } sas_state_e;
endpackage

/* File: dv/sas_core_model.sv */
// Behavioural comparator core that faces the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sas_core_model (
  input wire logic [7:0] level_i,
  input wire logic [7:0] trial_code_i,
  output logic compare_o
);
  // Decides on the level of the selected pin, even one driven as an output
  assign compare_o = level_i >= trial_code_i;
endmodule
`default_nettype wire

/* File: dv/sas_checker.sv */
// Port-level assertions of the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sas_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic sleep_i,
  input wire logic [3:0] compare_unit_mode_i,
  input wire logic ccp_event_i,
  input wire logic timer_reset_o,
  input wire logic sample_o,
  input wire logic [7:0] analog_pins_o,
  input wire logic module_power_o,
  input wire logic [7:0] port_read_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Trigger of the one compare mode that feeds the converter
  sequence s_trig;
    ccp_event_i && compare_unit_mode_i == sas_pkg::CCP_TRIGGER_MODE;
  endsequence
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  a_ready_in_access: assert property (s_setup |=> pready_o)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_trigger_timer: assert property (s_trig |=> timer_reset_o)
    else $error("timer reset missing after trigger");
  a_timer_no_cause: assert property (timer_reset_o |->
    $past(ccp_event_i) &&
    $past(compare_unit_mode_i) == sas_pkg::CCP_TRIGGER_MODE)
    else $error("timer reset without trigger");
  // Reset leaves every pin analog, the module off and no request
  a_reset_state: assert property ($fell(rst_i) |->
    analog_pins_o == 8'hff && !module_power_o && !irq_o)
    else $error("wrong state after reset");
  // Port read lags the mask by one cycle, so a steady mask must agree
  a_analog_reads_zero: assert property ($stable(analog_pins_o) |->
    (port_read_o & analog_pins_o) == 8'h00)
    else $error("analog pin read nonzero");
  a_wake_in_sleep: assert property (wake_o |->
    $past(sleep_i) ##1 !wake_o)
    else $error("wake outside sleep or too long");
  a_sample_powered: assert property (sample_o |-> module_power_o)
    else $error("sampling while powered down");
endmodule
bind sas_sequencer sas_checker chk (.*);
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench of the converter sequencer over APB
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] CTL = sas_pkg::IDX_CONTROL_ZERO;
  localparam logic [7:0] FLG = sas_pkg::IDX_PERIPH_FLAGS;
  localparam logic [7:0] RES = sas_pkg::IDX_RESULT;
  localparam logic [7:0] ENA = sas_pkg::IDX_PERIPH_ENABLES;
  localparam logic [7:0] PIN = sas_pkg::IDX_PIN_ROLE;
  localparam logic [7:0] IRQC = sas_pkg::IDX_IRQ_CONTROL;
  logic clock_i = 0, rst_i = 1, por_i = 1, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, sleep_i = 0, rc_half_tick_i = 0, ccp_event_i = 0;
  logic [9:0] paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o;
  logic [3:0] compare_unit_mode_i = 4'h0;
  logic [7:0] port_pins_i = 8'h00, lvl = 8'h00, level, q, ctl;
  logic [7:0] trial_code_o, analog_pins_o, port_read_o;
  logic pready_o, pslverr_o, timer_reset_o, sample_o, vref_external_o;
  logic module_power_o, irq_o, wake_o, compare_i, err, woke = 0;
  logic [2:0] channel_o;
  logic [7:0] mask [8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00,
    8'h00};
  logic [7:0] ids [6] = '{CTL, FLG, RES, ENA, PIN, IRQC};
  // RC: four delay clocks, then 19 ticks of unknown phase, 8 clocks apart
  int lo [4] = '{19, 76, 304, 150};
  int miscompares = 0, checks = 0, cyc = 0, n;
  sas_sequencer dut (.*);
  // Far side sees a level that depends on the chosen channel
  assign level = lvl ^ {5'h00, channel_o};
  sas_core_model core (.level_i(level), .trial_code_i(trial_code_o),
    .compare_o(compare_i));
  initial forever #50 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////
  // RC half ticks every 8 cycles, wake watch and the hang ceiling
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    rc_half_tick_i <= (cyc % 8) == 7;
    if (wake_o === 1'b1) woke = 1;
    if (cyc == 40000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; holds the request until ready, then idles a cycle
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= {24'h00_0000, d};
    @(posedge clock_i);
    penable_i <= 1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    q = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic await(input int lim);
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clock_i);
      n++;
    end
    chk("irq wait", irq_o, 1);
  endtask
  // Trigger pulse; timer reset is looked at in the cycle it stands
  task automatic trig(input logic exp);
    ccp_event_i <= 1;
    @(posedge clock_i);
    ccp_event_i <= 0;
    @(posedge clock_i);
    chk("timer reset", timer_reset_o, exp);
  endtask
  task automatic reset(input logic p);
    rst_i <= 1;
    por_i <= p;
    repeat (8) @(posedge clock_i);
    rst_i <= 0;
    por_i <= 0;
    @(posedge clock_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset(1);
    foreach (ids[i]) begin
      apb(ids[i], 0, 8'h00);
      chk("reset value", q, 8'h00);
    end
    apb(8'h20, 0, 8'h00);
    chk("unmapped error", err, 1);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      apb(PIN, 1, 8'hf8 | 8'(c));
      apb(PIN, 0, 8'h00);
      chk("pin role", q, 8'(c));
      port_pins_i <= 8'hff;
      repeat (3) @(posedge clock_i);
      chk("analog pins", analog_pins_o, mask[c]);
      chk("vref", vref_external_o, c == 1 || c == 3 || c == 5);
      chk("port read", port_read_o, ~mask[c]);
    end
    $display("test pin roles done");
    apb(ENA, 1, 8'h40);
    apb(IRQC, 1, 8'hc0);
    // Every clock select, with the setup order software must keep
    for (int s = 0; s < 4; s++) begin
      lvl <= 8'h3c + 8'(s * 49);
      ctl = {2'(s), 3'(s + 2), 3'b001};
      apb(CTL, 1, ctl);
      repeat (160) @(posedge clock_i);
      apb(FLG, 1, 8'h00);
      apb(CTL, 1, ctl | 8'h04);
      await(400);
      chk("latency", n >= lo[s] && n <= lo[s] + 12, 1);
      chk("channel", channel_o, 8'(s + 2));
      apb(RES, 0, 8'h00);
      chk("result", q, lvl ^ 8'(s + 2));
      apb(CTL, 0, 8'h00);
      chk("go cleared", q, ctl);
      apb(FLG, 0, 8'h00);
      chk("done flag", q, 8'h40);
    end
    $display("test conversions done");
    for (int g = 0; g < 4; g++) begin
      apb(IRQC, 1, 8'(g << 6));
      @(posedge clock_i);
      chk("irq gate", irq_o, g == 3);
    end
    apb(FLG, 1, 8'h00);
    @(posedge clock_i);
    chk("irq cleared", irq_o, 0);
    $display("test irq done");
    // Abort mid-conversion keeps the written result, then restart
    apb(RES, 1, 8'h5a);
    apb(CTL, 1, 8'h49);
    repeat (160) @(posedge clock_i);
    apb(CTL, 1, 8'h4d);
    repeat (30) @(posedge clock_i);
    apb(CTL, 1, 8'h49);
    repeat (40) @(posedge clock_i);
    apb(RES, 0, 8'h00);
    chk("result kept", q, 8'h5a);
    apb(FLG, 0, 8'h00);
    chk("no done", q, 8'h00);
    apb(CTL, 1, 8'h4d);
    await(400);
    apb(RES, 0, 8'h00);
    chk("after abort", q, lvl ^ 8'h01);
    $display("test abort done");
    apb(CTL, 1, 8'h48);
    apb(CTL, 1, 8'h4c);
    apb(CTL, 0, 8'h00);
    chk("go refused", q, 8'h48);
    compare_unit_mode_i <= 4'hb;
    trig(1);
    apb(CTL, 0, 8'h00);
    chk("trigger ignored", q, 8'h48);
    apb(CTL, 1, 8'h49);
    repeat (160) @(posedge clock_i);
    apb(FLG, 1, 8'h00);
    trig(1);
    apb(CTL, 0, 8'h00);
    chk("trigger go", q, 8'h4d);
    await(400);
    compare_unit_mode_i <= 4'ha;
    trig(0);
    $display("test trigger done");
    // Sleep: RC wakes with irq enabled, powers down without it
    apb(FLG, 1, 8'h00);
    apb(CTL, 1, 8'hc9);
    repeat (160) @(posedge clock_i);
    woke = 0;
    apb(CTL, 1, 8'hcd);
    sleep_i <= 1;
    await(400);
    // Let the wake watch see the edge that await stopped on
    @(posedge clock_i);
    chk("wake", woke, 1);
    sleep_i <= 0;
    apb(ENA, 1, 8'h00);
    apb(FLG, 1, 8'h00);
    lvl <= 8'ha7;
    repeat (160) @(posedge clock_i);
    apb(CTL, 1, 8'hcd);
    sleep_i <= 1;
    repeat (250) @(posedge clock_i);
    chk("rc sleep off", module_power_o, 0);
    apb(CTL, 0, 8'h00);
    chk("on kept", q, 8'hc9);
    apb(RES, 0, 8'h00);
    chk("sleep result", q, 8'ha6);
    sleep_i <= 0;
    apb(CTL, 1, 8'h89);
    repeat (160) @(posedge clock_i);
    apb(CTL, 1, 8'h8d);
    repeat (20) @(posedge clock_i);
    sleep_i <= 1;
    repeat (3) @(posedge clock_i);
    chk("sleep abort off", module_power_o, 0);
    apb(CTL, 0, 8'h00);
    chk("go aborted", q & 8'h05, 8'h01);
    sleep_i <= 0;
    apb(RES, 0, 8'h00);
    chk("abort result", q, 8'ha6);
    $display("test sleep done");
    apb(PIN, 1, 8'h07);
    reset(0);
    apb(RES, 0, 8'h00);
    chk("result over reset", q, 8'ha6);
    apb(PIN, 0, 8'h00);
    chk("pin role reset", q, 8'h00);
    apb(CTL, 0, 8'h00);
    chk("control reset", q, 8'h00);
    $display("test soft reset done");
    conclude();
  end
endmodule
`default_nettype wire
